// ==== pkg/cmw_map.svh ====
`ifndef CMW_MAP_SVH
`define CMW_MAP_SVH

// ----------------------------------------------------------------
// Datapath widths and shift amount.
// ----------------------------------------------------------------
`define CMW_DP_W 44
`define CMW_SHIFT 17
`define CMW_W_MIN 2
`define CMW_NORM_FW_MAX 18
`define CMW_DOT_FW_MAX 9
`define CMW_NORM_CW_MAX 44
`define CMW_DOT_CW_MAX 35

// ----------------------------------------------------------------
// Register stage indices.
// ----------------------------------------------------------------
`define CMW_NSTG 9
`define CMW_STG_X0 0
`define CMW_STG_Y0 1
`define CMW_STG_X1 2
`define CMW_STG_Y1 3
`define CMW_STG_ADD 4
`define CMW_STG_CIN 5
`define CMW_STG_CTL 6
`define CMW_STG_RES 7
`define CMW_STG_FLG 8
`define CMW_STG_CASC 9

// ----------------------------------------------------------------
// Reset value of every stage bit.
// ----------------------------------------------------------------
`define CMW_RST_BIT 1'b0

`endif

// ==== pkg/cmw_pkg.sv ====
`default_nettype none
`include "cmw_map.svh"
package cmw_pkg;

  // ----------------------------------------------------------------
  // Flavours and adder operations.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMW_FLV_ACC,
    CMW_FLV_ADDSUB,
    CMW_FLV_MULT
  } cmw_flavor_e;

  typedef enum logic [1:0] {
    CMW_OP_ADD,
    CMW_OP_SUB,
    CMW_OP_DYN
  } cmw_addop_e;

  // ----------------------------------------------------------------
  // Control inputs and datapath word.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sub_sel;
    logic cascade_feed_select;
    logic loopback_select;
    logic shift17_select;
  } cmw_ctrl_s;

  typedef logic signed [`CMW_DP_W-1:0] cmw_word_t;

endpackage : cmw_pkg
`default_nettype wire

// ==== hdl/cmw_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cmw_map.svh"
module cmw_stage #(
  parameter int W = 1,
  parameter bit REG = 1'b1
) (
  // Clock and clears.
  input wire logic sys_clk_i,
  input wire logic aclr_n_i,
  input wire logic sclr_n_i,
  // Enable and data.
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ----------------------------------------------------------------
  // Optional register or straight wire.
  // ----------------------------------------------------------------
  generate
    if (REG) begin : g_reg
      logic [W-1:0] q_q;
      always_ff @(posedge sys_clk_i or negedge aclr_n_i) begin
        if (!aclr_n_i) begin
          q_q <= {W{`CMW_RST_BIT}};
        end else if (!sclr_n_i) begin
          q_q <= {W{`CMW_RST_BIT}};
        end else if (en_i) begin
          q_q <= d_i;
        end
      end
      assign q_o = q_q;

      chk_stage_hold: assert property (@(posedge sys_clk_i) disable iff (!aclr_n_i)
        (sclr_n_i && !en_i) |=> $stable(q_q))
        else $error("Stage changed while its enable was low.");

      chk_stage_sclr: assert property (@(posedge sys_clk_i) disable iff (!aclr_n_i)
        !sclr_n_i |=> (q_q == '0))
        else $error("Stage not cleared by its synchronous clear.");
    end else begin : g_wire
      assign q_o = d_i;
    end
  endgenerate

endmodule : cmw_stage
`default_nettype wire

// ==== hdl/cmw_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cmw_map.svh"
module cmw_top
  import cmw_pkg::*;
#(
  parameter cmw_flavor_e FLAVOR = CMW_FLV_ACC,
  parameter bit TWO_LANE = 1'b0,
  parameter int X_W = 18,
  parameter int Y_W = 18,
  parameter int C_W = 44,
  parameter int RES_W = 44,
  parameter logic [`CMW_NSTG-1:0] REG_MASK = '1,
  parameter bit X_CONST_EN = 1'b0,
  parameter logic signed [17:0] X0_CONST = '0,
  parameter logic signed [17:0] X1_CONST = '0,
  parameter bit C_CONST_EN = 1'b0,
  parameter logic signed [43:0] C_CONST = '0,
  parameter cmw_addop_e ADD_OP = CMW_OP_DYN,
  parameter bit SHIFT_EN = 1'b1,
  parameter bit CIN_EN = 1'b1,
  parameter bit FLAG_EN = 1'b1,
  parameter bit CASC_OUT_EN = 1'b1,
  parameter bit CASC_IN_EN = 1'b1
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Per-stage clears and enables.
  input wire logic [`CMW_NSTG-1:0] stage_aclr_n_i,
  input wire logic [`CMW_NSTG-1:0] stage_sclr_n_i,
  input wire logic [`CMW_NSTG-1:0] stage_en_i,
  // Factors.
  input wire logic [X_W-1:0] mul_x0_i,
  input wire logic [Y_W-1:0] mul_y0_i,
  input wire logic [X_W-1:0] mul_x1_i,
  input wire logic [Y_W-1:0] mul_y1_i,
  // Adder operands and controls.
  input wire logic [C_W-1:0] addend_i,
  input wire logic carry_in_i,
  input wire logic [`CMW_DP_W-1:0] cascade_in_i,
  input wire cmw_ctrl_s ctrl_i,
  // Results.
  output logic [RES_W-1:0] result_o,
  output logic [`CMW_DP_W-1:0] cascade_out_o,
  output logic overflow_carry_flag_o
);

  // ----------------------------------------------------------------
  // Configuration checks.
  // ----------------------------------------------------------------
  localparam int FW_MAX = TWO_LANE ? `CMW_DOT_FW_MAX : `CMW_NORM_FW_MAX;
  localparam int CW_MAX = TWO_LANE ? `CMW_DOT_CW_MAX : `CMW_NORM_CW_MAX;
  localparam bit WIDTH_OK = (X_W >= `CMW_W_MIN) && (X_W <= FW_MAX) &&
    (Y_W >= `CMW_W_MIN) && (Y_W <= FW_MAX) &&
    (C_W >= `CMW_W_MIN) && (C_W <= CW_MAX) &&
    (RES_W >= `CMW_W_MIN) && (RES_W <= `CMW_DP_W);
  localparam bit HAS_ADD = (FLAVOR != CMW_FLV_MULT);
  localparam bit CASC_OK = CASC_IN_EN && (FLAVOR == CMW_FLV_ADDSUB);
  localparam bit LOOP_OK = (FLAVOR == CMW_FLV_ACC);

  // ----------------------------------------------------------------
  // Stage clears.
  // ----------------------------------------------------------------
  logic [`CMW_NSTG-1:0] stg_rst_n;
  assign stg_rst_n = {`CMW_NSTG{arst_n_i}} & stage_aclr_n_i;

  // ----------------------------------------------------------------
  // Input stages.
  // ----------------------------------------------------------------
  logic [X_W-1:0] x0_s;
  logic [Y_W-1:0] y0_s;
  logic [X_W-1:0] x1_s;
  logic [Y_W-1:0] y1_s;
  logic [C_W-1:0] add_s;
  logic cin_s;
  logic [`CMW_DP_W+3:0] ctl_s;
  cmw_ctrl_s ctrl_s;
  logic [`CMW_DP_W-1:0] casc_s;

  cmw_stage #(.W(X_W), .REG(REG_MASK[`CMW_STG_X0])) u_x0 (
    .sys_clk_i(sys_clk_i),
    .aclr_n_i(stg_rst_n[`CMW_STG_X0]),
    .sclr_n_i(stage_sclr_n_i[`CMW_STG_X0]),
    .en_i(stage_en_i[`CMW_STG_X0]),
    .d_i(mul_x0_i),
    .q_o(x0_s)
  );

  cmw_stage #(.W(Y_W), .REG(REG_MASK[`CMW_STG_Y0])) u_y0 (
    .sys_clk_i(sys_clk_i),
    .aclr_n_i(stg_rst_n[`CMW_STG_Y0]),
    .sclr_n_i(stage_sclr_n_i[`CMW_STG_Y0]),
    .en_i(stage_en_i[`CMW_STG_Y0]),
    .d_i(mul_y0_i),
    .q_o(y0_s)
  );

  cmw_stage #(.W(X_W), .REG(REG_MASK[`CMW_STG_X1])) u_x1 (
    .sys_clk_i(sys_clk_i),
    .aclr_n_i(stg_rst_n[`CMW_STG_X1]),
    .sclr_n_i(stage_sclr_n_i[`CMW_STG_X1]),
    .en_i(stage_en_i[`CMW_STG_X1]),
    .d_i(mul_x1_i),
    .q_o(x1_s)
  );

  cmw_stage #(.W(Y_W), .REG(REG_MASK[`CMW_STG_Y1])) u_y1 (
    .sys_clk_i(sys_clk_i),
    .aclr_n_i(stg_rst_n[`CMW_STG_Y1]),
    .sclr_n_i(stage_sclr_n_i[`CMW_STG_Y1]),
    .en_i(stage_en_i[`CMW_STG_Y1]),
    .d_i(mul_y1_i),
    .q_o(y1_s)
  );

  cmw_stage #(.W(C_W), .REG(REG_MASK[`CMW_STG_ADD])) u_add (
    .sys_clk_i(sys_clk_i),
    .aclr_n_i(stg_rst_n[`CMW_STG_ADD]),
    .sclr_n_i(stage_sclr_n_i[`CMW_STG_ADD]),
    .en_i(stage_en_i[`CMW_STG_ADD]),
    .d_i(addend_i),
    .q_o(add_s)
  );

  cmw_stage #(.W(1), .REG(REG_MASK[`CMW_STG_CIN])) u_cin (
    .sys_clk_i(sys_clk_i),
    .aclr_n_i(stg_rst_n[`CMW_STG_CIN]),
    .sclr_n_i(stage_sclr_n_i[`CMW_STG_CIN]),
    .en_i(stage_en_i[`CMW_STG_CIN]),
    .d_i(carry_in_i),
    .q_o(cin_s)
  );

  // The cascade word rides with the control stage so both line up.
  cmw_stage #(.W(`CMW_DP_W + 4), .REG(REG_MASK[`CMW_STG_CTL])) u_ctl (
    .sys_clk_i(sys_clk_i),
    .aclr_n_i(stg_rst_n[`CMW_STG_CTL]),
    .sclr_n_i(stage_sclr_n_i[`CMW_STG_CTL]),
    .en_i(stage_en_i[`CMW_STG_CTL]),
    .d_i({ctrl_i, cascade_in_i}),
    .q_o(ctl_s)
  );

  assign ctrl_s = ctl_s[`CMW_DP_W+3:`CMW_DP_W];
  assign casc_s = ctl_s[`CMW_DP_W-1:0];

  // ----------------------------------------------------------------
  // Factor selection and products.
  // ----------------------------------------------------------------
  cmw_word_t x0_e;
  cmw_word_t x1_e;
  cmw_word_t y0_e;
  cmw_word_t y1_e;
  cmw_word_t prod0;
  cmw_word_t prod1;
  cmw_word_t prod;
  cmw_word_t x0_k;
  cmw_word_t x1_k;

  assign x0_k = TWO_LANE ? cmw_word_t'($signed(X0_CONST[8:0]))
                         : cmw_word_t'(X0_CONST);
  assign x1_k = cmw_word_t'($signed(X1_CONST[8:0]));
  assign x0_e = X_CONST_EN ? x0_k : cmw_word_t'($signed(x0_s));
  assign x1_e = X_CONST_EN ? x1_k : cmw_word_t'($signed(x1_s));
  assign y0_e = cmw_word_t'($signed(y0_s));
  assign y1_e = cmw_word_t'($signed(y1_s));
  assign prod0 = x0_e * y0_e;
  assign prod1 = x1_e * y1_e;
  assign prod = TWO_LANE ? (prod0 + prod1) : prod0;

  // ----------------------------------------------------------------
  // Addend and second operand.
  // ----------------------------------------------------------------
  cmw_word_t c_k;
  cmw_word_t c_e;
  cmw_word_t acc_q;
  cmw_word_t opd_raw;
  cmw_word_t opd;
  logic sel_casc;
  logic sel_loop;
  logic sel_shift;

  assign c_k = TWO_LANE ? cmw_word_t'($signed(C_CONST[34:0]))
                        : C_CONST;
  assign c_e = !HAS_ADD ? '0 : C_CONST_EN ? c_k
             : cmw_word_t'($signed(add_s));
  assign sel_casc = CASC_OK && ctrl_s.cascade_feed_select;
  assign sel_loop = LOOP_OK && !ctrl_s.cascade_feed_select
                 && ctrl_s.loopback_select;
  assign sel_shift = SHIFT_EN && ctrl_s.shift17_select;
  assign opd_raw = sel_casc ? cmw_word_t'(casc_s)
                 : sel_loop ? acc_q : '0;
  assign opd = sel_shift ? (opd_raw >>> `CMW_SHIFT) : opd_raw;

  // ----------------------------------------------------------------
  // Adder stage.
  // ----------------------------------------------------------------
  cmw_word_t base;
  cmw_word_t term;
  logic sub;
  logic cin_e;
  logic [`CMW_DP_W:0] sum_x;
  cmw_word_t sum;
  logic ovf;

  assign sub = HAS_ADD && ((ADD_OP == CMW_OP_SUB)
            || ((ADD_OP == CMW_OP_DYN) && ctrl_s.sub_sel));
  assign cin_e = HAS_ADD && CIN_EN && cin_s;
  assign base = c_e + opd;
  assign term = sub ? ~prod : prod;
  assign sum_x = {base[`CMW_DP_W-1], base} + {term[`CMW_DP_W-1], term}
               + {{`CMW_DP_W{1'b0}}, sub} + {{`CMW_DP_W{1'b0}}, cin_e};
  assign sum = HAS_ADD ? sum_x[`CMW_DP_W-1:0] : prod;
  assign ovf = HAS_ADD && FLAG_EN
            && (sum_x[`CMW_DP_W] != sum_x[`CMW_DP_W-1]);

  // ----------------------------------------------------------------
  // Loopback register, clocked even when the result is not.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge stg_rst_n[`CMW_STG_RES]) begin
    if (!stg_rst_n[`CMW_STG_RES]) begin
      acc_q <= '0;
    end else if (!stage_sclr_n_i[`CMW_STG_RES]) begin
      acc_q <= '0;
    end else if (stage_en_i[`CMW_STG_RES]) begin
      acc_q <= sum;
    end
  end

  // ----------------------------------------------------------------
  // Output stages.
  // ----------------------------------------------------------------
  logic [RES_W-1:0] res_s;
  logic flg_s;

  cmw_stage #(.W(RES_W), .REG(REG_MASK[`CMW_STG_RES])) u_res (
    .sys_clk_i(sys_clk_i),
    .aclr_n_i(stg_rst_n[`CMW_STG_RES]),
    .sclr_n_i(stage_sclr_n_i[`CMW_STG_RES]),
    .en_i(stage_en_i[`CMW_STG_RES]),
    .d_i(sum[RES_W-1:0]),
    .q_o(res_s)
  );

  cmw_stage #(.W(1), .REG(REG_MASK[`CMW_STG_FLG])) u_flg (
    .sys_clk_i(sys_clk_i),
    .aclr_n_i(stg_rst_n[`CMW_STG_FLG]),
    .sclr_n_i(stage_sclr_n_i[`CMW_STG_FLG]),
    .en_i(stage_en_i[`CMW_STG_FLG]),
    .d_i(ovf),
    .q_o(flg_s)
  );

  assign result_o = res_s;
  assign overflow_carry_flag_o = flg_s;
  assign cascade_out_o = CASC_OUT_EN
    ? `CMW_DP_W'($signed(res_s)) : '0;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_acc_idle;
    stage_sclr_n_i[`CMW_STG_RES] && !stage_en_i[`CMW_STG_RES];
  endsequence

  sequence s_acc_same;
    $stable(acc_q);
  endsequence

  chk_width_range: assert property (WIDTH_OK)
    else $error("Operand width outside the allowed range.");

  chk_acc_hold: assert property (
    (stg_rst_n[`CMW_STG_RES] ##0 s_acc_idle) |=> s_acc_same)
    else $error("Loopback value moved with result enable low.");

  chk_acc_load: assert property (
    (stg_rst_n[`CMW_STG_RES] && stage_sclr_n_i[`CMW_STG_RES]
     && stage_en_i[`CMW_STG_RES] && sel_loop && sel_shift && LOOP_OK)
    |=> ($past(opd) == ($past(acc_q) >>> `CMW_SHIFT)) && (acc_q == $past(sum)))
    else $error("Shifted loopback not used for the next value.");

  chk_casc_sext: assert property (CASC_OUT_EN |->
    ($signed(cascade_out_o) == $signed(result_o)))
    else $error("Cascade output is not the sign-extended result.");

  chk_zero_opd: assert property (
    (!ctrl_s.cascade_feed_select && !ctrl_s.loopback_select) |-> (opd == '0))
    else $error("Second operand not zero with no source selected.");

  chk_casc_feed: assert property (
    (CASC_OK && ctrl_s.cascade_feed_select) |->
    (opd == (sel_shift ? ($signed(casc_s) >>> `CMW_SHIFT) : $signed(casc_s))))
    else $error("Cascade input not routed to the second operand.");

  chk_sub_sign: assert property ((HAS_ADD && !cin_e) |->
    (sum == (sub ? (base - prod) : (base + prod))))
    else $error("Adder stage sign does not follow the operation.");

  chk_ovf_flag: assert property (ovf == (HAS_ADD && FLAG_EN &&
    (base[`CMW_DP_W-1] == term[`CMW_DP_W-1])
    && (sum[`CMW_DP_W-1] != base[`CMW_DP_W-1]) && !sub && !cin_e)
    || (ovf && (sub || cin_e)))
    else $error("Overflow flag disagrees with the addition.");

  chk_dot_sum: assert property (TWO_LANE |->
    (prod == (x0_e * y0_e) + (x1_e * y1_e)))
    else $error("Two-lane product is not the sum of both lanes.");

  chk_mult_plain: assert property ((FLAVOR == CMW_FLV_MULT) |->
    ((sum == prod) && !ovf))
    else $error("Plain multiplier result is not the bare product.");

endmodule : cmw_top
`default_nettype wire

// ==== verification/cmw_fabric_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Upstream fabric and cascade source.
// ----------------------------------------------------------------
module cmw_fabric_model
  import cmw_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Requests from the bench.
  input wire logic [43:0] word_i,
  input wire logic sub_i,
  // Registered outputs toward the block.
  output logic [43:0] cascade_out_o,
  output logic sub_sel_o
);
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cascade_out_o <= 44'h000_0000_0000;
      sub_sel_o <= 1'b0;
    end else begin
      cascade_out_o <= word_i;
      sub_sel_o <= sub_i;
    end
  end
endmodule : cmw_fabric_model
`default_nettype wire

// ==== verification/cmw_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmw_top_bench;
  import cmw_pkg::*;
  typedef struct packed {
    logic [17:0] x;
    logic [17:0] y;
    logic [43:0] c;
    logic cin;
    logic [43:0] cd;
    logic [3:0] ctl;
  } cmw_row_s;
  // ----------------------------------------------------------------
  // Stimulus and wiring.
  // ----------------------------------------------------------------
  logic sys_clk, arst_n, cin, sub_req, sub_w;
  logic [8:0] aclr_n, sclr_n, en;
  logic [17:0] x0, y0;
  logic [43:0] addend, casc_req, casc_w, result, casc_out;
  logic [3:0] ctl_q;
  logic flag;
  cmw_ctrl_s ctrl_w;
  logic [8:0] ax0, ay0, ax1, ay1;
  logic [34:0] ac;
  logic [43:0] a_res, m_casc;
  logic [19:0] m_res;
  logic m_flag;
  cmw_ctrl_s actl;
  int errors, cmp_count;
  cmw_row_s rows [0:9] = '{
    '{18'h00003, 18'h00005, 44'h000_0000_0064, 1'b0, 44'h000_0000_0000, 4'h0},
    '{18'h00007, 18'h3FFFE, 44'h000_0000_000A, 1'b0, 44'h000_0000_0000, 4'h8},
    '{18'h00002, 18'h00002, 44'h000_0000_0001, 1'b0, 44'h123_4567_89AB, 4'h4},
    '{18'h00001, 18'h00001, 44'h000_0000_0000, 1'b0, 44'hF00_0000_0000, 4'h5},
    '{18'h00001, 18'h00001, 44'h000_0000_0005, 1'b0, 44'h000_0000_1234, 4'h2},
    '{18'h00000, 18'h00000, 44'hFFF_FFFF_FFFF, 1'b1, 44'h000_0000_0000, 4'h0},
    '{18'h00001, 18'h00001, 44'h7FF_FFFF_FFFF, 1'b0, 44'h000_0000_0000, 4'h0},
    '{18'h00001, 18'h00001, 44'h800_0000_0000, 1'b0, 44'h000_0000_0000, 4'h8},
    '{18'h20000, 18'h20000, 44'h000_0000_0000, 1'b0, 44'h000_0000_0000, 4'h0},
    '{18'h1FFFF, 18'h1FFFF, 44'h000_0000_0001, 1'b1, 44'h7FF_FFFF_FFFF, 4'hD}
  };
  assign ctrl_w = cmw_ctrl_s'({sub_w, ctl_q[2:0]});
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  cmw_fabric_model cmw_fabric_model_inst (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .word_i(casc_req), .sub_i(sub_req),
    .cascade_out_o(casc_w), .sub_sel_o(sub_w)
  );
  cmw_top #(.FLAVOR(CMW_FLV_ADDSUB)) cmw_top_inst (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .stage_aclr_n_i(aclr_n), .stage_sclr_n_i(sclr_n),
    .stage_en_i(en), .mul_x0_i(x0), .mul_y0_i(y0), .mul_x1_i(18'h00000), .mul_y1_i(18'h00000),
    .addend_i(addend), .carry_in_i(cin), .cascade_in_i(casc_w), .ctrl_i(ctrl_w),
    .result_o(result), .cascade_out_o(casc_out), .overflow_carry_flag_o(flag)
  );
  // Two-lane accumulator with the result and flag stages left unregistered.
  if (1'b1) begin : g_acc
    cmw_top #(.FLAVOR(CMW_FLV_ACC), .TWO_LANE(1'b1), .X_W(9), .Y_W(9), .C_W(35), .REG_MASK(9'h07F),
      .ADD_OP(CMW_OP_ADD)) cmw_top_inst (
      .sys_clk_i(sys_clk), .arst_n_i(arst_n), .stage_aclr_n_i(aclr_n), .stage_sclr_n_i(sclr_n),
      .stage_en_i(en), .mul_x0_i(ax0), .mul_y0_i(ay0), .mul_x1_i(ax1), .mul_y1_i(ay1),
      .addend_i(ac), .carry_in_i(1'b0), .cascade_in_i(44'h000_0000_0000), .ctrl_i(actl),
      .result_o(a_res), .cascade_out_o(), .overflow_carry_flag_o()
    );
  end
  // Plain multiplier with a constant first factor and a narrow result.
  if (1'b1) begin : g_mul
    cmw_top #(.FLAVOR(CMW_FLV_MULT), .RES_W(20), .X_CONST_EN(1'b1), .X0_CONST(18'sh3FFFD)) cmw_top_inst (
      .sys_clk_i(sys_clk), .arst_n_i(arst_n), .stage_aclr_n_i(aclr_n), .stage_sclr_n_i(sclr_n),
      .stage_en_i(en), .mul_x0_i(x0), .mul_y0_i(y0), .mul_x1_i(18'h00000), .mul_y1_i(18'h00000),
      .addend_i(addend), .carry_in_i(1'b1), .cascade_in_i(casc_w), .ctrl_i(ctrl_w),
      .result_o(m_res), .cascade_out_o(m_casc), .overflow_carry_flag_o(m_flag)
    );
  end
  // ----------------------------------------------------------------
  // Reference arithmetic and checks.
  // ----------------------------------------------------------------
  function automatic logic [43:0] exp_sum(input cmw_row_s r, output logic ov);
    longint opd;
    longint s;
    logic signed [43:0] t;
    opd = r.ctl[2] ? longint'(signed'(r.cd)) : 64'sh0;
    if (r.ctl[0]) opd = opd >>> 17;
    t = r.c + opd[43:0];
    s = longint'(signed'(r.x)) * longint'(signed'(r.y));
    s = r.ctl[3] ? longint'(t) - s : longint'(t) + s;
    s = s + longint'({1'b0, r.cin});
    ov = (s[63:43] != {21{s[43]}});
    return s[43:0];
  endfunction : exp_sum
  task automatic check(input logic [43:0] seen, input logic [43:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  logic [43:0] prev, e;
  logic ov;
  task automatic run_row(input cmw_row_s r);
    e = exp_sum(r, ov);
    @(posedge sys_clk);
    casc_req <= r.cd;
    sub_req <= r.ctl[3];
    @(posedge sys_clk);
    x0 <= r.x;
    y0 <= r.y;
    addend <= r.c;
    cin <= r.cin;
    ctl_q <= r.ctl;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(result, prev);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(result, e);
    check(casc_out, e);
    check({43'h0, flag}, {43'h0, ov});
    prev = e;
  endtask : run_row
  // ----------------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------------
  cmw_row_s r;
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    aclr_n = 9'h1FF;
    sclr_n = 9'h1FF;
    en = 9'h1FF;
    {x0, y0, addend, cin, casc_req, sub_req, ctl_q} = '0;
    {ax0, ay0, ax1, ay1, ac, actl} = '0;
    prev = 44'h000_0000_0000;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    check(result, 44'h000_0000_0000);
    check({43'h0, flag}, 44'h000_0000_0000);
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    r = rows[9];
    r.c = 44'h000_0000_0777;
    e = exp_sum(r, ov);
    @(posedge sys_clk);
    en[7] <= 1'b0;
    addend <= r.c;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check(result, prev);
    @(posedge sys_clk);
    en[7] <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(result, e);
    @(posedge sys_clk);
    sclr_n[7] <= 1'b0;
    @(posedge sys_clk);
    sclr_n[7] <= 1'b1;
    @(negedge sys_clk);
    check(result, 44'h000_0000_0000);
    check(casc_out, 44'h000_0000_0000);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(result, e);
    @(posedge sys_clk);
    aclr_n[7] <= 1'b0;
    @(negedge sys_clk);
    check(result, 44'h000_0000_0000);
    @(posedge sys_clk);
    aclr_n[7] <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(result, e);
    @(posedge sys_clk);
    {ax0, ay0, ax1, ay1} <= {9'h003, 9'h004, 9'h1FE, 9'h005};
    ac <= 35'h4_0000_0000;
    actl <= cmw_ctrl_s'(4'hA);
    sclr_n[7] <= 1'b0;
    @(posedge sys_clk);
    sclr_n[7] <= 1'b1;
    @(negedge sys_clk);
    check(a_res, 44'hFFC_0000_0002);
    @(posedge sys_clk);
    actl <= cmw_ctrl_s'(4'hB);
    @(negedge sys_clk);
    check(a_res, 44'hFF8_0000_0004);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(a_res, 44'hFFB_FFFC_0002);
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(a_res, 44'hFFB_FFFE_0000);
    @(posedge sys_clk);
    y0 <= 18'h00005;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check({24'h0, m_res}, 44'h000_000F_FFF1);
    check(m_casc, 44'hFFF_FFFF_FFF1);
    check({43'h0, m_flag}, 44'h000_0000_0000);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    @(negedge sys_clk);
    check(result, 44'h000_0000_0000);
    check(m_casc, 44'h000_0000_0000);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    print_verdict();
  end
endmodule : cmw_top_bench
`default_nettype wire
